// [logic/bbx_exec.v]
// execution datapath for add, and, bit clear and bit test with skip
//
// Behaviour
// - Opcode 00 0111 adds the accumulator to the addressed file register and updates carry, nibble overflow and zero.
// - Opcode 00 0101 ands the accumulator with the file register and updates only zero.
// - For add and and, destination bit 0 writes the accumulator and 1 writes the file register back.
// - The file operand is a 7-bit address from 0 to 127 and the destination is one bit.
// - Add and and finish in one cycle: decode in Q1, read in Q2, compute in Q3, write in Q4.
// - Opcode 01 00bb clears bit b of the addressed register in one cycle and leaves all flags alone.
// - Opcode 01 10bb reads the register in Q2 with bit index 0 to 7, writes nothing and changes no flag.
// - A tested bit of zero discards the word fetched in the next Q1 and runs a second no-operation cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bbx_defs.vh"

module bbx_exec (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // instruction fetch side
  input wire instr_valid,
  input wire [13:0] instr_word,
  output wire instr_ready,
  output reg nop_cycle_q,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);

  // ==========================================================
  // phases
  wire [3:0] phase_q;
  wire q1;
  wire q2;
  wire q3;
  wire q4;

  bbx_qphase u_phase (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .phase_q(phase_q)
  );

  assign q1 = phase_q[0];
  assign q2 = phase_q[1];
  assign q3 = phase_q[2];
  assign q4 = phase_q[3];

  // ==========================================================
  // state
  reg [7:0] file_mem [0:`BBX_FILE_DEPTH-1];
  reg [7:0] acc_q;
  reg carry_q;
  reg nibble_overflow_flag_q;
  reg zero_q;
  reg skip_q;
  reg ex_valid_q;
  reg [13:0] instr_q;
  reg [7:0] rd_q;
  reg [7:0] res_q;
  reg res_carry_q;
  reg res_nibble_q;
  reg test_bit_q;
  reg rd_hold_q;

  // ==========================================================
  // decode
  wire [6:0] f_addr;
  wire dest_file;
  wire [2:0] bit_idx;
  wire is_add;
  wire is_and;
  wire is_clr;
  wire is_tst;
  wire fetch_take;

  assign f_addr = instr_q[`BBX_FILE_ADDR_W-1:0];
  assign dest_file = instr_q[`BBX_DEST_BIT];
  assign bit_idx = instr_q[9:7];
  assign is_add = ex_valid_q && (instr_q[13:8] == `BBX_OP_ADD_ACC_TO_FILE);
  assign is_and = ex_valid_q && (instr_q[13:8] == `BBX_OP_AND_ACC_WITH_FILE);
  assign is_clr = ex_valid_q && (instr_q[13:10] == `BBX_OP_CLEAR_FILE_BIT);
  assign is_tst = ex_valid_q && (instr_q[13:10] == `BBX_OP_TEST_BIT_SKIP_WHEN_ZERO);

  assign instr_ready = q1;
  assign fetch_take = q1 && instr_valid;

  // ==========================================================
  // q1 decode and skip handling
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ex_valid_q <= 1'b0;
      instr_q <= 14'h0000;
      nop_cycle_q <= 1'b0;
    end else if (q1) begin
      // a pending skip turns the fetched word into a no-operation
      ex_valid_q <= fetch_take && !skip_q;
      nop_cycle_q <= skip_q;
      if (fetch_take) begin
        instr_q <= instr_word;
      end
    end
  end

  // ==========================================================
  // q2 read and q3 compute
  wire [8:0] sum_full;
  wire [4:0] sum_low;
  wire [7:0] bit_mask;

  assign sum_full = {1'b0, acc_q} + {1'b0, rd_q};
  assign sum_low = {1'b0, acc_q[3:0]} + {1'b0, rd_q[3:0]};
  assign bit_mask = 8'h01 << bit_idx;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_q <= 8'h00;
      res_q <= 8'h00;
      res_carry_q <= 1'b0;
      res_nibble_q <= 1'b0;
      test_bit_q <= 1'b1;
    end else begin
      if (q2) begin
        rd_q <= file_mem[f_addr];
      end
      if (q3) begin
        res_carry_q <= sum_full[8];
        res_nibble_q <= sum_low[4];
        test_bit_q <= |(rd_q & bit_mask);
        if (is_add) begin
          res_q <= sum_full[7:0];
        end else if (is_and) begin
          res_q <= acc_q & rd_q;
        end else begin
          res_q <= rd_q & ~bit_mask;
        end
      end
    end
  end

  // ==========================================================
  // bus decode
  wire bus_wr;
  wire wr_lane;
  wire file_sel;
  wire [6:0] bus_faddr;

  assign wr_lane = avs_byteenable[0];
  assign bus_wr = q1 && avs_write && wr_lane;
  assign file_sel = avs_address[`BBX_FILE_BASE_BIT];
  assign bus_faddr = avs_address[8:2];

  // writes land in q1, reads are captured in q1 and answered in q2
  assign avs_waitrequest = avs_write ? !q1 : (avs_read ? !(q2 && rd_hold_q) : 1'b1);

  // ==========================================================
  // q4 write back and bus writes
  always @(posedge clk_sys) begin
    if (q4 && (is_clr || ((is_add || is_and) && dest_file))) begin
      file_mem[f_addr] <= res_q;
    end else if (bus_wr && file_sel) begin
      file_mem[bus_faddr] <= avs_writedata[7:0];
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      acc_q <= `BBX_RST_ACC;
      carry_q <= 1'b0;
      nibble_overflow_flag_q <= 1'b0;
      zero_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      if (q4) begin
        if ((is_add || is_and) && !dest_file) begin
          acc_q <= res_q;
        end
        if (is_add) begin
          carry_q <= res_carry_q;
          nibble_overflow_flag_q <= res_nibble_q;
        end
        if (is_add || is_and) begin
          zero_q <= (res_q == 8'h00);
        end
        skip_q <= is_tst && !test_bit_q;
      end else if (q1) begin
        skip_q <= 1'b0;
        if (bus_wr && !file_sel && (avs_address == `BBX_OFF_ACC)) begin
          acc_q <= avs_writedata[7:0];
        end
        if (bus_wr && !file_sel && (avs_address == `BBX_OFF_STATUS)) begin
          carry_q <= avs_writedata[`BBX_ST_CARRY];
          nibble_overflow_flag_q <= avs_writedata[`BBX_ST_NIBBLE];
          zero_q <= avs_writedata[`BBX_ST_ZERO];
        end
      end
    end
  end

  // ==========================================================
  // read data capture
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (file_sel) begin
      rd_mux = {24'h00_0000, file_mem[bus_faddr]};
    end else if (avs_address == `BBX_OFF_ACC) begin
      rd_mux = {24'h00_0000, acc_q};
    end else if (avs_address == `BBX_OFF_STATUS) begin
      rd_mux[`BBX_ST_CARRY] = carry_q;
      rd_mux[`BBX_ST_NIBBLE] = nibble_overflow_flag_q;
      rd_mux[`BBX_ST_ZERO] = zero_q;
      rd_mux[`BBX_ST_SKIP] = skip_q;
      rd_mux[`BBX_ST_NOP] = nop_cycle_q;
    end else if (avs_address == `BBX_OFF_LAST_INSTR) begin
      rd_mux = {18'h0_0000, instr_q};
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
      rd_hold_q <= 1'b0;
    end else begin
      rd_hold_q <= q1 && avs_read && !avs_write;
      if (q1 && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// [logic/bbx_defs.vh]
// constants of the byte and bit operation execution block
`ifndef BBX_DEFS_VH
`define BBX_DEFS_VH

// ==========================================================
// opcode fields
`define BBX_OP_ADD_ACC_TO_FILE 6'h07
`define BBX_OP_AND_ACC_WITH_FILE 6'h05
`define BBX_OP_CLEAR_FILE_BIT 4'h4
`define BBX_OP_TEST_BIT_SKIP_WHEN_ZERO 4'h6
`define BBX_INSTR_W 14
`define BBX_FILE_ADDR_W 7
`define BBX_FILE_DEPTH 128
`define BBX_DEST_BIT 7

// ==========================================================
// register byte addresses
`define BBX_ADDR_W 10
`define BBX_OFF_ACC 10'h000
`define BBX_OFF_STATUS 10'h004
`define BBX_OFF_LAST_INSTR 10'h008
`define BBX_FILE_BASE_BIT 9

// ==========================================================
// status fields
`define BBX_ST_CARRY 0
`define BBX_ST_NIBBLE 1
`define BBX_ST_ZERO 2
`define BBX_ST_SKIP 3
`define BBX_ST_NOP 4

// ==========================================================
// reset values
`define BBX_RST_ACC 8'h00
`define BBX_RST_PHASE 4'h1

`endif

// [logic/bbx_qphase.v]
// four phase machine cycle generator
`timescale 1ns/1ps
`default_nettype none
`include "bbx_defs.vh"

module bbx_qphase (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // one-hot phase, bit 0 is the first phase
  output reg [3:0] phase_q
);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_q <= `BBX_RST_PHASE;
    end else begin
      phase_q <= {phase_q[2:0], phase_q[3]};
    end
  end

endmodule
`default_nettype wire

// [testbench/bbx_exec_sva.sv]
// port checks of the execution block
`timescale 1ns/1ps
`default_nettype none
module bbx_exec_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // fetch and bus
  input wire logic instr_ready,
  input wire logic nop_cycle_q,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_gap;
    !instr_ready [*3] ##1 instr_ready;
  endsequence
  sequence s_nop;
    nop_cycle_q [*4] ##1 !nop_cycle_q;
  endsequence
  a_phase_rotate: assert property (instr_ready |=> s_gap)
    else $error("ready pattern broken");
  a_nop_start: assert property ($rose(nop_cycle_q) |-> $past(instr_ready))
    else $error("nop start off phase");
  a_nop_length: assert property ($rose(nop_cycle_q) |-> s_nop)
    else $error("nop length wrong");
  a_nop_end: assert property ($fell(nop_cycle_q) |-> $past(instr_ready))
    else $error("nop end off phase");
  a_write_phase: assert property (avs_write && !avs_waitrequest |-> instr_ready)
    else $error("write off phase");
  a_read_phase: assert property (avs_read && !avs_waitrequest |-> $past(instr_ready))
    else $error("read off phase");
  a_read_bound: assert property ($rose(avs_read) |-> ##[1:5] !avs_waitrequest)
    else $error("read too slow");
  a_read_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("readdata moved");
endmodule
bind bbx_exec bbx_exec_sva bbx_exec_sva_inst (.clk_sys, .rst_b, .instr_ready, .nop_cycle_q,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
`default_nettype wire

// [testbench/bbx_fetch_model.sv]
// fetch side model offering one word until taken
`timescale 1ns/1ps
`default_nettype none
module bbx_fetch_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bench side
  input wire logic load,
  input wire logic [13:0] word,
  // block side
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [13:0] instr_word
);
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      instr_valid <= 1'b0;
      instr_word <= 14'h0000;
    end else if (load) begin
      instr_valid <= 1'b1;
      instr_word <= word;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      // stale word must not look valid
      instr_word <= ~instr_word;
    end
  end
endmodule
`default_nettype wire

// [testbench/byte_and_bit_op_exec_tb_top.sv]
// testbench of the execution block
`timescale 1ns/1ps
`default_nettype none
`include "bbx_defs.vh"
module byte_and_bit_op_exec_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic load = 1'b0;
  logic [13:0] word = 14'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic instr_valid, instr_ready, nop_cycle_q, avs_waitrequest;
  logic [13:0] instr_word;
  int err_total = 0;
  int comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  bbx_fetch_model bbx_fetch_model_inst (.clk_sys, .rst_b, .load, .word, .instr_ready,
    .instr_valid, .instr_word);
  bbx_exec bbx_exec_inst (.clk_sys, .rst_b, .instr_valid, .instr_word, .instr_ready,
    .nop_cycle_q, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
  // ====================
  // tasks
  task automatic summarize;
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 12) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 12);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    tmo(n);
  endtask
  task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, (a == `BBX_OFF_STATUS) ? q & 32'h0000_0007 : q, e);
  endtask
  task automatic exec(input logic [13:0] w);
    int n;
    n = 0;
    load <= 1'b1;
    word <= w;
    @(posedge clk_sys);
    load <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (instr_valid !== 1'b0 && n < 12);
    tmo(n);
  endtask
  // ====================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(1'b1, `BBX_OFF_ACC, 32'h0000_00f8);
    bus(1'b1, 10'h214, 32'h0000_0008);
    exec({`BBX_OP_ADD_ACC_TO_FILE, 1'b0, 7'h05});
    rd("add acc", `BBX_OFF_ACC, 32'h0000_0000);
    rd("add flags", `BBX_OFF_STATUS, 32'h0000_0007);
    rd("add file", 10'h214, 32'h0000_0008);
    bus(1'b1, `BBX_OFF_ACC, 32'h0000_0017);
    bus(1'b1, 10'h214, 32'h0000_00c2);
    exec({`BBX_OP_AND_ACC_WITH_FILE, 1'b1, 7'h05});
    rd("and file", 10'h214, 32'h0000_0002);
    rd("and acc", `BBX_OFF_ACC, 32'h0000_0017);
    rd("and flags", `BBX_OFF_STATUS, 32'h0000_0003);
    bus(1'b1, 10'h3fc, 32'h0000_00c7);
    exec({`BBX_OP_CLEAR_FILE_BIT, 3'h7, 7'h7f});
    rd("clr file", 10'h3fc, 32'h0000_0047);
    rd("clr flags", `BBX_OFF_STATUS, 32'h0000_0003);
    exec({`BBX_OP_TEST_BIT_SKIP_WHEN_ZERO, 3'h3, 7'h7f});
    exec({`BBX_OP_ADD_ACC_TO_FILE, 1'b0, 7'h7f});
    chk("nop", {31'h0000_0000, nop_cycle_q}, 32'h0000_0001);
    rd("skip acc", `BBX_OFF_ACC, 32'h0000_0017);
    rd("test file", 10'h3fc, 32'h0000_0047);
    rd("test flags", `BBX_OFF_STATUS, 32'h0000_0003);
    exec({`BBX_OP_TEST_BIT_SKIP_WHEN_ZERO, 3'h0, 7'h7f});
    exec({`BBX_OP_ADD_ACC_TO_FILE, 1'b0, 7'h7f});
    chk("no nop", {31'h0000_0000, nop_cycle_q}, 32'h0000_0000);
    rd("next acc", `BBX_OFF_ACC, 32'h0000_005e);
    rd("next flags", `BBX_OFF_STATUS, 32'h0000_0000);
    bus(1'b1, 10'h100, 32'h0000_0055);
    rd("unmapped", 10'h100, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
